// file: htsc_pkg.sv
// Constants and types for the humidity and temperature sensor control block
package htsc_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned BOOT_US   = 3000;
  localparam int unsigned TICK_US   = 1000;
  localparam int unsigned CONV9_US  = 225;
  localparam int unsigned CONV11_US = 350;
  localparam int unsigned CONV14_US = 610;
  localparam int unsigned BOOT_CYC   = BOOT_US * CLK_MHZ;
  localparam int unsigned TICK_CYC   = TICK_US * CLK_MHZ;
  localparam int unsigned CONV9_CYC  = CONV9_US * CLK_MHZ;
  localparam int unsigned CONV11_CYC = CONV11_US * CLK_MHZ;
  localparam int unsigned CONV14_CYC = CONV14_US * CLK_MHZ;
  // Auto sample periods in ms, code 0 is on demand
  localparam int unsigned RATE_MS [8] = '{0, 200, 500, 1000, 5000, 10000, 60000, 120000};
  // ==========================================
  // Bus identity and byte framing
  localparam logic [6:0] BUS_ID_BASE = 7'h40;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  // Identification bytes, values arbitrary
  localparam logic [7:0] MFR_ID_LO = 8'h5a;
  localparam logic [7:0] MFR_ID_HI = 8'h5b;
  localparam logic [7:0] DEV_ID_LO = 8'h5c;
  localparam logic [7:0] DEV_ID_HI = 8'h5d;
  // ==========================================
  // Register pointers
  localparam logic [7:0] REG_TEMP_LO   = 8'h00;
  localparam logic [7:0] REG_TEMP_HI   = 8'h01;
  localparam logic [7:0] REG_HUM_LO    = 8'h02;
  localparam logic [7:0] REG_HUM_HI    = 8'h03;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_TEMP_MAX  = 8'h05;
  localparam logic [7:0] REG_HUM_MAX   = 8'h06;
  localparam logic [7:0] REG_MASK      = 8'h07;
  localparam logic [7:0] REG_TEMP_OFS  = 8'h08;
  localparam logic [7:0] REG_HUM_OFS   = 8'h09;
  localparam logic [7:0] REG_TTHR_LO   = 8'h0a;
  localparam logic [7:0] REG_TTHR_HI   = 8'h0b;
  localparam logic [7:0] REG_HTHR_LO   = 8'h0c;
  localparam logic [7:0] REG_HTHR_HI   = 8'h0d;
  localparam logic [7:0] REG_IRQ_CFG   = 8'h0e;
  localparam logic [7:0] REG_MEAS_CFG  = 8'h0f;
  localparam logic [7:0] REG_MFR_LO    = 8'hfc;
  localparam logic [7:0] REG_MFR_HI    = 8'hfd;
  localparam logic [7:0] REG_DEV_LO    = 8'hfe;
  localparam logic [7:0] REG_DEV_HI    = 8'hff;
  localparam logic [7:0] THR_LO_RST    = 8'hff;
  // ==========================================
  // Field codes
  localparam logic [1:0] RES_14   = 2'h0;
  localparam logic [1:0] RES_11   = 2'h1;
  localparam logic [1:0] RES_9    = 2'h2;
  localparam logic [1:0] SEL_TEMP = 2'h1;
  localparam logic [1:0] SEL_HUM  = 2'h2;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_PTR  = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam int THR_HA = 3;
  localparam int THR_HB = 2;
  localparam int THR_TA = 1;
  localparam int THR_TB = 0;
  // ==========================================
  // Types
  typedef struct packed {
    logic       conv_done;
    logic       humid_above;
    logic       humid_below;
    logic       temp_above;
    logic       temp_below;
    logic [2:0] rsvd;
  } htsc_flag_type;
  typedef struct packed {
    logic       soft_rst;
    logic [2:0] auto_sample_rate;
    logic       heat;
    logic       pin_en;
    logic       pol;
    logic       mode;
  } htsc_irq_cfg_type;
  typedef struct packed {
    logic [1:0] temp_res;
    logic [1:0] hum_res;
    logic       rsvd;
    logic [1:0] sel;
    logic       go;
  } htsc_meas_cfg_type;
  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_RX    = 3'b001,
    L_ACK   = 3'b010,
    L_TX    = 3'b011,
    L_TXACK = 3'b100
  } htsc_link_type;
  typedef enum logic [1:0] {
    M_BOOT  = 2'b00,
    M_SLEEP = 2'b01,
    M_CONV  = 2'b10
  } htsc_meas_type;
endpackage

// file: htsc_top.sv
// Sensor control: two-wire slave register file, measurement sequencer, alert pin
`timescale 1ns/1ps
module htsc_top
  import htsc_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES   = BOOT_CYC,
  parameter int unsigned TICK_CYCLES   = TICK_CYC,
  parameter int unsigned CONV9_CYCLES  = CONV9_CYC,
  parameter int unsigned CONV11_CYCLES = CONV11_CYC,
  parameter int unsigned CONV14_CYCLES = CONV14_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_b_out,
  input  wire logic        bus_id_select_pin_in,
  input  wire logic [13:0] temp_sample_in,
  input  wire logic [13:0] humid_sample_in,
  output logic             alert_output_pin_out,
  output logic             alert_output_pin_oe_b_out,
  output logic             heater_on_out,
  output logic             measuring_out,
  output logic             ready_out
);
  // ==========================================
  // Pin synchronisers
  logic [1:0]        scl_sync_q;
  logic [1:0]        sda_sync_q;
  logic [1:0]        sel_sync_q;
  logic              scl_prev_q;
  logic              sda_prev_q;
  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              bus_start;
  logic              bus_stop;
  // Two flops per pin, then an edge history flop for clock and data
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sel_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      sel_sync_q <= {sel_sync_q[0], bus_id_select_pin_in};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  // Bus events
  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  // ==========================================
  // Register state
  htsc_link_type     link_q;
  htsc_meas_type     meas_q;
  htsc_flag_type     mask_q;
  htsc_flag_type     status_rd;
  htsc_irq_cfg_type  irq_cfg_q;
  htsc_meas_cfg_type meas_cfg_q;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic [1:0]        idx_q;
  logic              rd_mode_q;
  logic              acked_q;
  logic [7:0]        ptr_q;
  logic [7:0]        rd_data;
  logic [15:0]       temp_res_q;
  logic [15:0]       hum_res_q;
  logic [15:0]       temp_nxt;
  logic [15:0]       hum_nxt;
  logic [7:0]        temp_max_q;
  logic [7:0]        hum_max_q;
  logic [7:0]        temp_ofs_q;
  logic [7:0]        hum_ofs_q;
  logic [7:0]        tthr_lo_q;
  logic [7:0]        tthr_hi_q;
  logic [7:0]        hthr_lo_q;
  logic [7:0]        hthr_hi_q;
  logic              drdy_q;
  logic [3:0]        thr_q;
  logic [3:0]        thr_d;
  logic [3:0]        thr_en;
  logic [3:0]        thr_cond;
  logic              addr_match;
  logic              ptr_ok;
  logic              wr_ok;
  logic              give_ack;
  logic              rx_done;
  logic              wr_strobe;
  logic              tx_load;
  logic              rd_status;
  logic              rd_result;
  logic              drive_low;
  // Byte decode
  assign addr_match = shift_q[7:1] == {BUS_ID_BASE[6:1], sel_sync_q[1]};
  assign ptr_ok     = (shift_q <= REG_MEAS_CFG) | (shift_q >= REG_MFR_LO);
  assign wr_ok      = (ptr_q >= REG_STATUS) & (ptr_q <= REG_MEAS_CFG);
  assign give_ack   = (idx_q == IDX_ADDR) ? addr_match :
                      (idx_q == IDX_PTR) ? ptr_ok : wr_ok;
  assign rx_done    = (link_q == L_RX) & (bit_cnt_q == BYTE_BITS) & scl_fall;
  assign wr_strobe  = rx_done & (idx_q == IDX_DATA) & wr_ok;
  assign tx_load    = scl_fall & (((link_q == L_ACK) & rd_mode_q) |
                                  ((link_q == L_TXACK) & acked_q));
  assign rd_status  = tx_load & (ptr_q == REG_STATUS);
  assign rd_result  = tx_load & (ptr_q <= REG_HUM_HI);
  assign drive_low  = (link_q == L_ACK) | ((link_q == L_TX) & ~shift_q[7]);
  // ==========================================
  // Two-wire slave byte engine
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_q    <= L_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      idx_q     <= IDX_ADDR;
      rd_mode_q <= 1'b0;
      acked_q   <= 1'b0;
    end else if (bus_start) begin
      link_q    <= L_RX;
      bit_cnt_q <= 4'h0;
      idx_q     <= IDX_ADDR;
    end else if (bus_stop) begin
      link_q <= L_IDLE;
    end else begin
      case (link_q)
        L_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (rx_done) begin
            link_q <= give_ack ? L_ACK : L_IDLE;
            idx_q  <= (idx_q == IDX_DATA) ? IDX_DATA : idx_q + 2'h1;
            if (idx_q == IDX_ADDR) begin
              rd_mode_q <= shift_q[0];
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            link_q    <= rd_mode_q ? L_TX : L_RX;
            bit_cnt_q <= 4'h0;
            if (rd_mode_q) begin
              shift_q <= rd_data;
            end
          end
        end
        L_TX: begin
          if (scl_fall) begin
            shift_q   <= {shift_q[6:0], 1'b1};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == LAST_BIT) begin
              link_q <= L_TXACK;
            end
          end
        end
        L_TXACK: begin
          if (scl_rise) begin
            acked_q <= ~sda_s;
          end else if (scl_fall) begin
            link_q    <= acked_q ? L_TX : L_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= rd_data;
          end
        end
        default: link_q <= L_IDLE;
      endcase
    end
  end
  // Register pointer: load, then step per data byte
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_q <= REG_TEMP_LO;
    end else if (rx_done & (idx_q == IDX_PTR) & give_ack) begin
      ptr_q <= shift_q;
    end else if (wr_strobe | tx_load) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end
  // Read data select
  assign status_rd = '{conv_done: drdy_q, humid_above: thr_q[THR_HA],
                       humid_below: thr_q[THR_HB], temp_above: thr_q[THR_TA],
                       temp_below: thr_q[THR_TB], rsvd: 3'h0};
  always_comb begin
    case (ptr_q)
      REG_TEMP_LO:  rd_data = temp_res_q[7:0];
      REG_TEMP_HI:  rd_data = temp_res_q[15:8];
      REG_HUM_LO:   rd_data = hum_res_q[7:0];
      REG_HUM_HI:   rd_data = hum_res_q[15:8];
      REG_STATUS:   rd_data = status_rd;
      REG_TEMP_MAX: rd_data = temp_max_q;
      REG_HUM_MAX:  rd_data = hum_max_q;
      REG_MASK:     rd_data = mask_q;
      REG_TEMP_OFS: rd_data = temp_ofs_q;
      REG_HUM_OFS:  rd_data = hum_ofs_q;
      REG_TTHR_LO:  rd_data = tthr_lo_q;
      REG_TTHR_HI:  rd_data = tthr_hi_q;
      REG_HTHR_LO:  rd_data = hthr_lo_q;
      REG_HTHR_HI:  rd_data = hthr_hi_q;
      REG_IRQ_CFG:  rd_data = irq_cfg_q;
      REG_MEAS_CFG: rd_data = meas_cfg_q;
      REG_MFR_LO:   rd_data = MFR_ID_LO;
      REG_MFR_HI:   rd_data = MFR_ID_HI;
      REG_DEV_LO:   rd_data = DEV_ID_LO;
      REG_DEV_HI:   rd_data = DEV_ID_HI;
      default:      rd_data = 8'hff;
    endcase
  end
  // ==========================================
  // Measurement sequencer
  logic [31:0] cnt_q;
  logic [31:0] tick_q;
  logic [31:0] ms_q;
  logic [31:0] conv_len;
  logic [31:0] t_cyc;
  logic [31:0] h_cyc;
  logic        t_en;
  logic        h_en;
  logic        auto_due_q;
  logic        auto_on;
  logic        tick;
  logic        conv_start;
  logic        conv_done;
  // Duration from resolution and selection
  assign t_en     = meas_cfg_q.sel != SEL_HUM;
  assign h_en     = meas_cfg_q.sel != SEL_TEMP;
  assign t_cyc    = (meas_cfg_q.temp_res == RES_11) ? CONV11_CYCLES : CONV14_CYCLES;
  assign h_cyc    = (meas_cfg_q.hum_res == RES_11) ? CONV11_CYCLES :
                    (meas_cfg_q.hum_res == RES_9) ? CONV9_CYCLES : CONV14_CYCLES;
  assign conv_len = (t_en ? t_cyc : 32'h0) + (h_en ? h_cyc : 32'h0);
  assign auto_on  = irq_cfg_q.auto_sample_rate != 3'h0;
  assign tick     = auto_on & (tick_q == TICK_CYCLES - 1);
  assign conv_start = (meas_q == M_SLEEP) & (meas_cfg_q.go | auto_due_q);
  assign conv_done  = (meas_q == M_CONV) & (cnt_q == conv_len - 32'h1);
  // Boot wait, sleep, convert
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meas_q <= M_BOOT;
      cnt_q  <= 32'h0;
    end else begin
      case (meas_q)
        M_BOOT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == BOOT_CYCLES - 1) begin
            meas_q <= M_SLEEP;
          end
        end
        M_SLEEP: begin
          cnt_q <= 32'h0;
          if (conv_start) begin
            meas_q <= M_CONV;
          end
        end
        M_CONV: begin
          cnt_q <= cnt_q + 32'h1;
          if (conv_done) begin
            meas_q <= M_SLEEP;
          end
        end
        default: meas_q <= M_SLEEP;
      endcase
    end
  end
  // Periodic wake timer in ms ticks
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_q     <= 32'h0;
      ms_q       <= 32'h0;
      auto_due_q <= 1'b0;
    end else begin
      tick_q     <= (!auto_on | tick) ? 32'h0 : tick_q + 32'h1;
      ms_q       <= !auto_on ? 32'h0 :
                    !tick ? ms_q :
                    (ms_q == RATE_MS[irq_cfg_q.auto_sample_rate] - 1) ? 32'h0 : ms_q + 32'h1;
      auto_due_q <= auto_on & ((tick & (ms_q == RATE_MS[irq_cfg_q.auto_sample_rate] - 1)) |
                               (auto_due_q & ~conv_start));
    end
  end
  // ==========================================
  // Results, peaks and flags
  assign temp_nxt = t_en ? {temp_sample_in, 2'b00} : temp_res_q;
  assign hum_nxt  = h_en ? {humid_sample_in, 2'b00} : hum_res_q;
  assign thr_en   = {mask_q.humid_above, mask_q.humid_below,
                     mask_q.temp_above, mask_q.temp_below};
  assign thr_cond = {hum_nxt[15:8] > hthr_hi_q, hum_nxt[15:8] < hthr_lo_q,
                     temp_nxt[15:8] > tthr_hi_q, temp_nxt[15:8] < tthr_lo_q};
  // Latch until status read, or follow each new value
  for (genvar i = 0; i < 4; i++) begin : g_thr
    assign thr_d[i] = irq_cfg_q.mode ?
                      ((thr_q[i] & ~rd_status) | (conv_done & thr_en[i] & thr_cond[i])) :
                      (conv_done ? (thr_en[i] & thr_cond[i]) : thr_q[i]);
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      temp_res_q <= 16'h0000;
      hum_res_q  <= 16'h0000;
      drdy_q     <= 1'b0;
      thr_q      <= 4'h0;
    end else begin
      thr_q  <= thr_d;
      drdy_q <= (drdy_q & ~(rd_status | rd_result)) | (conv_done & mask_q.conv_done);
      if (conv_done) begin
        temp_res_q <= temp_nxt;
        hum_res_q  <= hum_nxt;
      end
    end
  end
  // ==========================================
  // Configuration writes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_q     <= '0;
      irq_cfg_q  <= '0;
      meas_cfg_q <= '0;
      temp_max_q <= 8'h00;
      hum_max_q  <= 8'h00;
      temp_ofs_q <= 8'h00;
      hum_ofs_q  <= 8'h00;
      tthr_lo_q  <= THR_LO_RST;
      tthr_hi_q  <= 8'h00;
      hthr_lo_q  <= THR_LO_RST;
      hthr_hi_q  <= 8'h00;
    end else begin
      if (conv_start) begin
        meas_cfg_q.go <= 1'b0;
      end
      if (conv_done & (temp_nxt[15:8] > temp_max_q)) begin
        temp_max_q <= temp_nxt[15:8];
      end
      if (conv_done & (hum_nxt[15:8] > hum_max_q)) begin
        hum_max_q <= hum_nxt[15:8];
      end
      if (wr_strobe) begin
        case (ptr_q)
          REG_TEMP_MAX: temp_max_q <= shift_q;
          REG_HUM_MAX:  hum_max_q <= shift_q;
          REG_MASK:     mask_q <= shift_q;
          REG_TEMP_OFS: temp_ofs_q <= shift_q;
          REG_HUM_OFS:  hum_ofs_q <= shift_q;
          REG_TTHR_LO:  tthr_lo_q <= shift_q;
          REG_TTHR_HI:  tthr_hi_q <= shift_q;
          REG_HTHR_LO:  hthr_lo_q <= shift_q;
          REG_HTHR_HI:  hthr_hi_q <= shift_q;
          REG_IRQ_CFG:  irq_cfg_q <= shift_q;
          REG_MEAS_CFG: meas_cfg_q <= shift_q;
          default:      mask_q <= mask_q;
        endcase
      end
    end
  end
  // ==========================================
  // Output flops
  logic any_flag;
  assign any_flag = drdy_q | (|thr_q);
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_out                   <= 1'b1;
      sda_oe_b_out              <= 1'b1;
      alert_output_pin_out      <= 1'b0;
      alert_output_pin_oe_b_out <= 1'b1;
      heater_on_out             <= 1'b0;
      measuring_out             <= 1'b0;
      ready_out                 <= 1'b0;
    end else begin
      sda_out                   <= ~drive_low;
      sda_oe_b_out              <= ~drive_low;
      alert_output_pin_out      <= irq_cfg_q.pol ~^ any_flag;
      alert_output_pin_oe_b_out <= ~irq_cfg_q.pin_en;
      heater_on_out             <= irq_cfg_q.heat;
      measuring_out             <= meas_q == M_CONV;
      ready_out                 <= meas_q != M_BOOT;
    end
  end
  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  heater_follow_a: assert property ($rose(irq_cfg_q.heat) |=> heater_on_out)
    else $error("heater not on");
  pin_hiz_a: assert property (!irq_cfg_q.pin_en |=> alert_output_pin_oe_b_out)
    else $error("alert pin driven while disabled");
  drdy_set_a: assert property (conv_done && mask_q.conv_done |=> drdy_q)
    else $error("done flag not set");
  pin_level_a: assert property (1'b1 |=>
    alert_output_pin_out == ($past(irq_cfg_q.pol) ~^ $past(any_flag)))
    else $error("alert level wrong");
  temp_high_a: assert property (conv_done && mask_q.temp_above &&
    temp_nxt[15:8] > tthr_hi_q |=> thr_q[THR_TA]) else $error("temp above not set");
  latch_hold_a: assert property (irq_cfg_q.mode && thr_q[THR_TA] && !rd_status
    |=> thr_q[THR_TA]) else $error("latched flag lost");
  level_follow_a: assert property (!irq_cfg_q.mode && conv_done
    |=> thr_q[THR_TA] == $past(mask_q.temp_above && thr_cond[THR_TA]))
    else $error("level flag stale");
  conv_bound_a: assert property (meas_q == M_CONV |-> cnt_q < conv_len)
    else $error("conversion overran");
  result_lsb_a: assert property (conv_done && t_en |=>
    temp_res_q == $past(temp_nxt) && temp_res_q[1:0] == 2'b00) else $error("result stale");
  ptr_step_a: assert property (wr_strobe |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer not stepped");
  addr_nack_a: assert property (rx_done && idx_q == IDX_ADDR && !addr_match
    |=> link_q == L_IDLE ##1 sda_oe_b_out) else $error("foreign address acked");
  drdy_clear_a: assert property (rd_result && !conv_done |=> !drdy_q)
    else $error("done flag not cleared");
  conv_seen_c: cover property (conv_start ##[1:1000] conv_done);
  write_seen_c: cover property (wr_strobe);
  read_seen_c: cover property (tx_load ##[1:1000] tx_load);
endmodule

// file: htsc_bus_master.sv
// Two-wire bus master model facing the sensor block
`timescale 1ns/1ps
module htsc_bus_master (
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_out,
  output logic [8:0]      res_out,
  output logic            evt_out
);
  // =====
  // Idle: both lines released high, clock still
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    res_out = 9'h000;
    evt_out = 1'b0;
  end
  // Start or repeated start
  task automatic start();
    #40 sda_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  // Stop, then bus left idle
  task automatic stop();
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b1;
  endtask
  // One byte plus acknowledge bit; result is {ack seen, line bits}
  task automatic xfer(input logic [7:0] tx, input logic mack);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) begin
      #40 sda_out = tx[i];
      #40 scl_out = 1'b1;
      #40 r[i] = sda_in;
      #40 scl_out = 1'b0;
    end
    #40 sda_out = mack;
    #40 scl_out = 1'b1;
    #40 r[8] = ~sda_in;
    #40 scl_out = 1'b0;
    res_out = r;
    evt_out = ~evt_out;
  endtask
endmodule

// file: htsc_tb_top.sv
// Self-checking bench for the sensor control block
`timescale 1ns/1ps
module htsc_tb_top
  import htsc_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl, m_sda, sel, evt;
  logic [13:0] t_s, h_s;
  logic [8:0]  res;
  logic [16:0] lf = 17'h13d56;
  logic [6:0]  id;
  logic        sda_o, sda_oe_b, alert, alert_oe_b, heat, meas, rdy;
  logic [8:0]  expq[$];
  int          fails = 0;
  int          n_compared = 0;
  int          n_meas = 0;
  logic [7:0]  st;
  wire logic   sda_w = m_sda & (sda_o | sda_oe_b);
  // =====
  always #5 clk = ~clk;
  htsc_top #(.BOOT_CYCLES(20), .TICK_CYCLES(10), .CONV9_CYCLES(5), .CONV11_CYCLES(7),
    .CONV14_CYCLES(9)) u_htsc_top (.sys_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_b_out(sda_oe_b), .bus_id_select_pin_in(sel),
    .temp_sample_in(t_s), .humid_sample_in(h_s), .alert_output_pin_out(alert),
    .alert_output_pin_oe_b_out(alert_oe_b), .heater_on_out(heat), .measuring_out(meas),
    .ready_out(rdy));
  htsc_bus_master u_htsc_bus_master (.sda_in(sda_w), .scl_out(scl), .sda_out(m_sda),
    .res_out(res), .evt_out(evt));
  // Random source
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Note the expected answer, then send the byte
  task automatic xb(input logic [7:0] tx, input logic mack, input logic [8:0] e);
    expq.push_back(e);
    u_htsc_bus_master.xfer(tx, mack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic pk, input logic dk);
    u_htsc_bus_master.start();
    xb({id, 1'b0}, 1'b1, {1'b1, id, 1'b0});
    xb(p, 1'b1, {pk, p});
    xb(d, 1'b1, {dk, d});
    u_htsc_bus_master.stop();
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] v[$]);
    u_htsc_bus_master.start();
    xb({id, 1'b0}, 1'b1, {1'b1, id, 1'b0});
    xb(p, 1'b1, {1'b1, p});
    u_htsc_bus_master.start();
    xb({id, 1'b1}, 1'b1, {1'b1, id, 1'b1});
    foreach (v[i]) xb(8'hff, i == v.size() - 1, {i != v.size() - 1, v[i]});
    u_htsc_bus_master.stop();
  endtask
  // Monitor: each finished byte against the oldest note
  always @(evt) if ($time > 0) chk(res, expq.pop_front());
  // Cycles spent converting, seen away from the launching edge
  always @(negedge clk) if (meas === 1'b1) n_meas++;
  // Watchdog
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    sel = lf[0];
    id = BUS_ID_BASE | {6'h0, sel};
    lf = nx(lf);
    t_s = lf[13:0] | 14'h2000;
    lf = nx(lf);
    h_s = lf[13:0];
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk({5'h0, sda_o, sda_oe_b, alert_oe_b, heat}, 9'h00e);
    repeat (25) @(negedge clk);
    chk({8'h0, rdy}, 9'h001);
    u_htsc_bus_master.start();
    xb({id ^ 7'h01, 1'b0}, 1'b1, {1'b0, id ^ 7'h01, 1'b0});
    u_htsc_bus_master.stop();
    wr(REG_IRQ_CFG, 8'h0f, 1'b1, 1'b1);
    chk({6'h0, heat, alert_oe_b, alert}, 9'h004);
    wr(REG_MASK, 8'h90, 1'b1, 1'b1);
    wr(REG_MFR_LO, 8'h00, 1'b1, 1'b0);
    wr(8'h20, 8'h00, 1'b0, 1'b0);
    wr(REG_MEAS_CFG, 8'h01, 1'b1, 1'b1);
    repeat (40) @(negedge clk);
    chk({7'h0, meas, alert}, 9'h001);
    chk(9'(n_meas), 9'd18);
    rd(REG_TEMP_LO, '{{t_s[5:0], 2'b00}, t_s[13:6], {h_s[5:0], 2'b00}, h_s[13:6]});
    rd(REG_STATUS, '{8'h10});
    rd(REG_STATUS, '{8'h00});
    chk({8'h0, alert}, 9'h000);
    rd(REG_MFR_LO, '{MFR_ID_LO, MFR_ID_HI});
    wr(REG_IRQ_CFG, 8'h0c, 1'b1, 1'b1);
    chk({8'h0, alert}, 9'h001);
    wr(REG_IRQ_CFG, 8'h00, 1'b1, 1'b1);
    chk({7'h0, heat, alert_oe_b}, 9'h001);
    // Level mode, all thresholds, automatic wake at code 1, 11 and 9 bit
    st = {1'b1, h_s[13:6] > 8'h00, h_s[13:6] < 8'hff,
          t_s[13:6] > 8'h00, t_s[13:6] < 8'hff, 3'h0};
    wr(REG_MEAS_CFG, 8'h60, 1'b1, 1'b1);
    wr(REG_MASK, 8'hf8, 1'b1, 1'b1);
    wr(REG_IRQ_CFG, 8'h10, 1'b1, 1'b1);
    repeat (2100) @(negedge clk);
    chk(9'(n_meas), 9'd30);
    chk({8'h0, alert}, 9'h000);
    rd(REG_STATUS, '{st});
    chk({8'h0, alert}, 9'h000);
    wr(REG_IRQ_CFG, 8'h00, 1'b1, 1'b1);
    wrap_up();
  end
endmodule
